/* File: design/ilt_params.svh */
`ifndef ILT_PARAMS_SVH
`define ILT_PARAMS_SVH

// ************************************************************
// reset values
// ************************************************************
`define ILT_PC_RESET     16'h0000
`define ILT_FETCH_RESET  1'b1

// ************************************************************
// opcode patterns (? marks register or pointer select bits)
// ************************************************************
`define ILT_OP_CLR_A      8'hE4
`define ILT_OP_CPL_A      8'hF4
`define ILT_OP_RL_A       8'h23
`define ILT_OP_RLC_A      8'h33
`define ILT_OP_RR_A       8'h03
`define ILT_OP_RRC_A      8'h13
`define ILT_OP_SWAP_A     8'hC4
`define ILT_OP_MOV_A_RN   8'b1110_1???
`define ILT_OP_MOV_RN_A   8'b1111_1???
`define ILT_OP_XCH_A_RN   8'b1100_1???
`define ILT_OP_MOV_A_IND  8'b1110_011?
`define ILT_OP_MOV_IND_A  8'b1111_011?
`define ILT_OP_XCH_A_IND  8'b1100_011?
`define ILT_OP_MOV_A_DIR  8'hE5
`define ILT_OP_MOV_DIR_A  8'hF5
`define ILT_OP_MOV_RN_DIR 8'b1010_1???
`define ILT_OP_MOV_DIR_RN 8'b1000_1???
`define ILT_OP_XCH_A_DIR  8'hC5
`define ILT_OP_MOV_A_IMM  8'h74
`define ILT_OP_MOV_RN_IMM 8'b0111_1???
`define ILT_OP_MOV_IND_IMM 8'b0111_011?
`define ILT_OP_MOV_DIR_DIR 8'h85
`define ILT_OP_MOV_DIR_IMM 8'h75
`define ILT_OP_MOV_DIR_IND 8'b1000_011?
`define ILT_OP_MOV_IND_DIR 8'b1010_011?
`define ILT_OP_LOAD_DPTR  8'h90
`define ILT_OP_CODE_DPTR  8'h93
`define ILT_OP_CODE_PC    8'h83
`define ILT_OP_XRD_RI     8'b1110_001?
`define ILT_OP_XWR_RI     8'b1111_001?
`define ILT_OP_XRD_DPTR   8'hE0
`define ILT_OP_XWR_DPTR   8'hF0
`define ILT_OP_PUSH       8'hC0
`define ILT_OP_POP        8'hD0
`define ILT_OP_XCH_NIB    8'b1101_011?
`define ILT_OP_CLR_BIT    8'hC2
`define ILT_OP_SET_BIT    8'hD2
`define ILT_OP_CPL_BIT    8'hB2
`define ILT_OP_AND_C_BIT  8'h82
`define ILT_OP_CLR_C      8'hC3
`define ILT_OP_SET_C      8'hD3
`define ILT_OP_CPL_C      8'hB3

// ************************************************************
// length in bytes and time in clock cycles per class
// ************************************************************
`define ILT_LEN_ACC    2'h1
`define ILT_CYC_ACC    2'h1
`define ILT_LEN_REG    2'h1
`define ILT_CYC_REG    2'h1
`define ILT_LEN_IND    2'h1
`define ILT_CYC_IND    2'h2
`define ILT_LEN_DIR    2'h2
`define ILT_CYC_DIR    2'h2
`define ILT_LEN_IMM    2'h2
`define ILT_CYC_IMM    2'h2
`define ILT_LEN_DD     2'h3
`define ILT_CYC_DD     2'h3
`define ILT_LEN_DI     2'h3
`define ILT_CYC_DI     2'h3
`define ILT_LEN_ID     2'h2
`define ILT_CYC_ID     2'h2
`define ILT_LEN_DPTR   2'h3
`define ILT_CYC_DPTR   2'h3
`define ILT_LEN_CODE   2'h1
`define ILT_CYC_CODE   2'h3
`define ILT_LEN_XDATA  2'h1
`define ILT_CYC_XDATA  2'h3
`define ILT_LEN_STACK  2'h2
`define ILT_CYC_STACK  2'h2
`define ILT_LEN_NIB    2'h1
`define ILT_CYC_NIB    2'h2
`define ILT_LEN_BIT    2'h2
`define ILT_CYC_BIT    2'h2
`define ILT_LEN_CARRY  2'h1
`define ILT_CYC_CARRY  2'h1
`define ILT_LEN_UNK    2'h1
`define ILT_CYC_UNK    2'h1

`endif

/* File: design/ilt_pkg.sv */
package ilt_pkg;

	typedef logic [1:0]  ilt_len_t;
	typedef logic [1:0]  ilt_cyc_t;
	typedef logic [15:0] ilt_pc_t;

	typedef enum logic [1:0] {
		st_fetch,
		st_exec
	} ilt_state_e;

	typedef enum logic [3:0] {
		cls_acc,
		cls_reg,
		cls_ind,
		cls_dir,
		cls_imm,
		cls_dd,
		cls_di,
		cls_id,
		cls_dptr,
		cls_code,
		cls_xdata,
		cls_stack,
		cls_nib,
		cls_bit,
		cls_carry,
		cls_unk
	} ilt_class_e;

endpackage

/* File: design/ilt_decode.sv */
`timescale 1ns/1ps
`include "ilt_params.svh"

module ilt_decode (
	input  wire logic [7:0]        opcode,
	output ilt_pkg::ilt_len_t      len,
	output ilt_pkg::ilt_cyc_t      cyc,
	output logic                   known
);
	import ilt_pkg::*;

	function automatic ilt_class_e classify(input logic [7:0] op);
		casez (op)
			`ILT_OP_CLR_A, `ILT_OP_CPL_A, `ILT_OP_RL_A, `ILT_OP_RLC_A,
			`ILT_OP_RR_A, `ILT_OP_RRC_A, `ILT_OP_SWAP_A:  return cls_acc;
			`ILT_OP_MOV_A_RN, `ILT_OP_MOV_RN_A,
			`ILT_OP_XCH_A_RN:                             return cls_reg;
			`ILT_OP_MOV_A_IND, `ILT_OP_MOV_IND_A,
			`ILT_OP_XCH_A_IND:                            return cls_ind;
			`ILT_OP_MOV_A_DIR, `ILT_OP_MOV_DIR_A, `ILT_OP_MOV_RN_DIR,
			`ILT_OP_MOV_DIR_RN, `ILT_OP_XCH_A_DIR:        return cls_dir;
			`ILT_OP_MOV_A_IMM, `ILT_OP_MOV_RN_IMM,
			`ILT_OP_MOV_IND_IMM:                          return cls_imm;
			`ILT_OP_MOV_DIR_DIR:                          return cls_dd;
			`ILT_OP_MOV_DIR_IMM:                          return cls_di;
			`ILT_OP_MOV_DIR_IND, `ILT_OP_MOV_IND_DIR:     return cls_id;
			`ILT_OP_LOAD_DPTR:                            return cls_dptr;
			`ILT_OP_CODE_DPTR, `ILT_OP_CODE_PC:           return cls_code;
			`ILT_OP_XRD_RI, `ILT_OP_XWR_RI, `ILT_OP_XRD_DPTR,
			`ILT_OP_XWR_DPTR:                             return cls_xdata;
			`ILT_OP_PUSH, `ILT_OP_POP:                    return cls_stack;
			`ILT_OP_XCH_NIB:                              return cls_nib;
			`ILT_OP_CLR_BIT, `ILT_OP_SET_BIT, `ILT_OP_CPL_BIT,
			`ILT_OP_AND_C_BIT:                            return cls_bit;
			`ILT_OP_CLR_C, `ILT_OP_SET_C, `ILT_OP_CPL_C:  return cls_carry;
			default:                                      return cls_unk;
		endcase
	endfunction

	ilt_class_e cls;

	always_comb begin
		cls   = classify(opcode);
		known = 1'b1;
		case (cls)
			cls_acc:   {len, cyc} = {`ILT_LEN_ACC, `ILT_CYC_ACC};
			cls_reg:   {len, cyc} = {`ILT_LEN_REG, `ILT_CYC_REG};
			cls_ind:   {len, cyc} = {`ILT_LEN_IND, `ILT_CYC_IND};
			cls_dir:   {len, cyc} = {`ILT_LEN_DIR, `ILT_CYC_DIR};
			cls_imm:   {len, cyc} = {`ILT_LEN_IMM, `ILT_CYC_IMM};
			cls_dd:    {len, cyc} = {`ILT_LEN_DD, `ILT_CYC_DD};
			cls_di:    {len, cyc} = {`ILT_LEN_DI, `ILT_CYC_DI};
			cls_id:    {len, cyc} = {`ILT_LEN_ID, `ILT_CYC_ID};
			cls_dptr:  {len, cyc} = {`ILT_LEN_DPTR, `ILT_CYC_DPTR};
			cls_code:  {len, cyc} = {`ILT_LEN_CODE, `ILT_CYC_CODE};
			cls_xdata: {len, cyc} = {`ILT_LEN_XDATA, `ILT_CYC_XDATA};
			cls_stack: {len, cyc} = {`ILT_LEN_STACK, `ILT_CYC_STACK};
			cls_nib:   {len, cyc} = {`ILT_LEN_NIB, `ILT_CYC_NIB};
			cls_bit:   {len, cyc} = {`ILT_LEN_BIT, `ILT_CYC_BIT};
			cls_carry: {len, cyc} = {`ILT_LEN_CARRY, `ILT_CYC_CARRY};
			default: begin
				// outside this subset: step one byte so fetch never stalls
				len   = `ILT_LEN_UNK;
				cyc   = `ILT_CYC_UNK;
				known = 1'b0;
			end
		endcase
	end

endmodule

/* File: design/ilt_seq.sv */
// Operation
// - accumulator clear/complement/rotate/swap: 1 byte, 1 cycle
// - register to/from/exchange accumulator: 1 byte, 1 cycle
// - accumulator with indirect RAM: 1 byte, 2 cycles
// - direct byte moves: 2 bytes, 2 cycles
// - immediate loads: 2 bytes, 2 cycles
// - direct to direct: 3 bytes, 3 cycles
// - immediate to direct: 3 bytes, 3 cycles
// - indirect and direct copies: 2 bytes, 2 cycles
// - load data pointer: 3 bytes, 3 cycles
// - code memory read: 1 byte, 3 cycles
// - external data access: 1 byte, 3 cycles
// - push and pop: 2 bytes, 2 cycles
// - nibble exchange indirect: 1 byte, 2 cycles
// - direct bit operations: 2 bytes, 2 cycles
`timescale 1ns/1ps
`include "ilt_params.svh"

module ilt_seq (
	input  wire logic              clock,
	input  wire logic              rst_n,
	input  wire logic              instr_valid,
	input  wire logic [7:0]        instr_byte,
	output logic                   fetch_req,
	output ilt_pkg::ilt_pc_t       pc,
	output logic                   busy,
	output ilt_pkg::ilt_len_t      instr_len,
	output ilt_pkg::ilt_cyc_t      instr_cycles,
	output logic                   instr_illegal,
	output logic                   instr_done
);
	import ilt_pkg::*;

	// ************************************************************
	// helpers
	// ************************************************************
	function automatic ilt_pc_t advance(input ilt_pc_t p,
		input ilt_len_t l);
		return 16'(p + {14'h0000, l});
	endfunction

	function automatic ilt_cyc_t less_one(input ilt_cyc_t c);
		return 2'(c - 2'h1);
	endfunction

	// ************************************************************
	// decode of the opcode byte
	// ************************************************************
	ilt_len_t   dec_len;
	ilt_cyc_t   dec_cyc;
	logic       dec_known;

	ilt_decode u_decode (
		.opcode (instr_byte),
		.len    (dec_len),
		.cyc    (dec_cyc),
		.known  (dec_known)
	);

	// ************************************************************
	// sequencer state
	// ************************************************************
	ilt_state_e state;
	ilt_state_e next_state;
	ilt_cyc_t   cnt;
	ilt_cyc_t   next_cnt;
	ilt_pc_t    next_pc;
	ilt_len_t   next_instr_len;
	ilt_cyc_t   next_instr_cycles;
	logic       next_instr_illegal;
	logic       next_fetch_req;
	logic       next_busy;
	logic       next_instr_done;
	logic       take;

	// opcode byte only counts while waiting for one
	assign take = (state == st_fetch) && instr_valid;

	always_comb begin
		next_state         = state;
		next_cnt           = cnt;
		next_pc            = pc;
		next_instr_len     = instr_len;
		next_instr_cycles  = instr_cycles;
		next_instr_illegal = instr_illegal;
		next_fetch_req     = fetch_req;
		next_busy          = busy;
		next_instr_done    = 1'b0;
		case (state)
			st_fetch: begin
				if (instr_valid) begin
					next_state         = st_exec;
					next_instr_len     = dec_len;
					next_instr_cycles  = dec_cyc;
					next_instr_illegal = !dec_known;
					next_cnt           = less_one(dec_cyc);
					next_fetch_req     = 1'b0;
					next_busy          = 1'b1;
				end
			end
			st_exec: begin
				if (cnt == 2'h0) begin
					// hold the fetch until the whole cycle count has run
					next_state      = st_fetch;
					next_pc         = advance(pc, instr_len);
					next_fetch_req  = 1'b1;
					next_busy       = 1'b0;
					next_instr_done = 1'b1;
				end else begin
					next_cnt = less_one(cnt);
				end
			end
			default: begin
				next_state     = st_fetch;
				next_fetch_req = 1'b1;
				next_busy      = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			state         <= st_fetch;
			cnt           <= 2'h0;
			pc            <= `ILT_PC_RESET;
			instr_len     <= 2'h0;
			instr_cycles  <= 2'h0;
			instr_illegal <= 1'b0;
			fetch_req     <= `ILT_FETCH_RESET;
			busy          <= 1'b0;
			instr_done    <= 1'b0;
		end else begin
			state         <= next_state;
			cnt           <= next_cnt;
			pc            <= next_pc;
			instr_len     <= next_instr_len;
			instr_cycles  <= next_instr_cycles;
			instr_illegal <= next_instr_illegal;
			fetch_req     <= next_fetch_req;
			busy          <= next_busy;
			instr_done    <= next_instr_done;
		end
	end

	// ************************************************************
	// checks on length and cycle count per opcode class
	// ************************************************************
	sequence s_take_op(logic hit);
		take && hit;
	endsequence

	sequence s_shape(ilt_len_t l, ilt_cyc_t c);
		busy && !fetch_req && (instr_len == l) && (instr_cycles == c);
	endsequence

	property p_acc;
		@(posedge clock) disable iff (!rst_n)
		s_take_op(instr_byte inside {`ILT_OP_CLR_A, `ILT_OP_CPL_A,
			`ILT_OP_RL_A, `ILT_OP_RLC_A, `ILT_OP_RR_A, `ILT_OP_RRC_A,
			`ILT_OP_SWAP_A}) |=> s_shape(2'h1, 2'h1);
	endproperty
	a_acc: assert property (p_acc)
		else $error("accumulator op shape wrong");

	property p_reg;
		@(posedge clock) disable iff (!rst_n)
		s_take_op((instr_byte ==? `ILT_OP_MOV_A_RN) ||
			(instr_byte ==? `ILT_OP_MOV_RN_A) ||
			(instr_byte ==? `ILT_OP_XCH_A_RN)) |=> s_shape(2'h1, 2'h1);
	endproperty
	a_reg: assert property (p_reg)
		else $error("register move shape wrong");

	property p_ind;
		@(posedge clock) disable iff (!rst_n)
		s_take_op((instr_byte ==? `ILT_OP_MOV_A_IND) ||
			(instr_byte ==? `ILT_OP_MOV_IND_A)) |=> s_shape(2'h1, 2'h2);
	endproperty
	a_ind: assert property (p_ind)
		else $error("indirect move shape wrong");

	property p_dir;
		@(posedge clock) disable iff (!rst_n)
		s_take_op((instr_byte == `ILT_OP_MOV_A_DIR) ||
			(instr_byte == `ILT_OP_MOV_DIR_A) ||
			(instr_byte ==? `ILT_OP_MOV_RN_DIR) ||
			(instr_byte ==? `ILT_OP_MOV_DIR_RN)) |=> s_shape(2'h2, 2'h2);
	endproperty
	a_dir: assert property (p_dir)
		else $error("direct move shape wrong");

	property p_imm;
		@(posedge clock) disable iff (!rst_n)
		s_take_op((instr_byte == `ILT_OP_MOV_A_IMM) ||
			(instr_byte ==? `ILT_OP_MOV_RN_IMM) ||
			(instr_byte ==? `ILT_OP_MOV_IND_IMM)) |=> s_shape(2'h2, 2'h2);
	endproperty
	a_imm: assert property (p_imm)
		else $error("immediate load shape wrong");

	property p_dd;
		@(posedge clock) disable iff (!rst_n)
		s_take_op(instr_byte == `ILT_OP_MOV_DIR_DIR) |=> s_shape(2'h3, 2'h3);
	endproperty
	a_dd: assert property (p_dd)
		else $error("direct to direct shape wrong");

	property p_di;
		@(posedge clock) disable iff (!rst_n)
		s_take_op(instr_byte == `ILT_OP_MOV_DIR_IMM) |=> s_shape(2'h3, 2'h3);
	endproperty
	a_di: assert property (p_di)
		else $error("immediate to direct shape wrong");

	property p_id;
		@(posedge clock) disable iff (!rst_n)
		s_take_op((instr_byte ==? `ILT_OP_MOV_DIR_IND) ||
			(instr_byte ==? `ILT_OP_MOV_IND_DIR)) |=> s_shape(2'h2, 2'h2);
	endproperty
	a_id: assert property (p_id)
		else $error("indirect direct copy shape wrong");

	property p_dptr;
		@(posedge clock) disable iff (!rst_n)
		s_take_op(instr_byte == `ILT_OP_LOAD_DPTR) |=> s_shape(2'h3, 2'h3);
	endproperty
	a_dptr: assert property (p_dptr)
		else $error("pointer load shape wrong");

	property p_code;
		@(posedge clock) disable iff (!rst_n)
		s_take_op((instr_byte == `ILT_OP_CODE_DPTR) ||
			(instr_byte == `ILT_OP_CODE_PC)) |=> s_shape(2'h1, 2'h3);
	endproperty
	a_code: assert property (p_code)
		else $error("code read shape wrong");

	property p_xdata;
		@(posedge clock) disable iff (!rst_n)
		s_take_op((instr_byte ==? `ILT_OP_XRD_RI) ||
			(instr_byte ==? `ILT_OP_XWR_RI) ||
			(instr_byte == `ILT_OP_XRD_DPTR) ||
			(instr_byte == `ILT_OP_XWR_DPTR)) |=> s_shape(2'h1, 2'h3);
	endproperty
	a_xdata: assert property (p_xdata)
		else $error("external data shape wrong");

	property p_stack;
		@(posedge clock) disable iff (!rst_n)
		s_take_op((instr_byte == `ILT_OP_PUSH) ||
			(instr_byte == `ILT_OP_POP)) |=> s_shape(2'h2, 2'h2);
	endproperty
	a_stack: assert property (p_stack)
		else $error("stack op shape wrong");

	property p_nib;
		@(posedge clock) disable iff (!rst_n)
		s_take_op(instr_byte ==? `ILT_OP_XCH_NIB) |=> s_shape(2'h1, 2'h2);
	endproperty
	a_nib: assert property (p_nib)
		else $error("nibble exchange shape wrong");

	property p_bit;
		@(posedge clock) disable iff (!rst_n)
		s_take_op(instr_byte inside {`ILT_OP_CLR_BIT, `ILT_OP_SET_BIT,
			`ILT_OP_CPL_BIT, `ILT_OP_AND_C_BIT}) |=> s_shape(2'h2, 2'h2);
	endproperty
	a_bit: assert property (p_bit)
		else $error("bit op shape wrong");

	// ************************************************************
	// checks on sequencing
	// ************************************************************
	sequence s_run(ilt_cyc_t c);
		take ##1 (instr_cycles == c);
	endsequence

	property p_run1;
		@(posedge clock) disable iff (!rst_n)
		s_run(2'h1) |-> busy ##1 (fetch_req && instr_done && !busy);
	endproperty
	a_run1: assert property (p_run1)
		else $error("one cycle op did not refetch on time");

	property p_run2;
		@(posedge clock) disable iff (!rst_n)
		s_run(2'h2) |-> busy[*2] ##1 (fetch_req && instr_done && !busy);
	endproperty
	a_run2: assert property (p_run2)
		else $error("two cycle op did not refetch on time");

	property p_run3;
		@(posedge clock) disable iff (!rst_n)
		s_run(2'h3) |-> (busy && !fetch_req)[*3] ##1
			(fetch_req && instr_done && !busy);
	endproperty
	a_run3: assert property (p_run3)
		else $error("three cycle op did not refetch on time");

	property p_pc_step;
		@(posedge clock) disable iff (!rst_n)
		instr_done |-> (pc == advance($past(pc), instr_len));
	endproperty
	a_pc_step: assert property (p_pc_step)
		else $error("pc did not advance by length");

	property p_pc_hold;
		@(posedge clock) disable iff (!rst_n)
		!instr_done && $past(rst_n) |-> $stable(pc);
	endproperty
	a_pc_hold: assert property (p_pc_hold)
		else $error("pc moved without a finished op");

	property p_excl;
		@(posedge clock) disable iff (!rst_n)
		fetch_req != busy;
	endproperty
	a_excl: assert property (p_excl)
		else $error("fetch request during execution");

	property p_unk;
		@(posedge clock) disable iff (!rst_n)
		s_take_op(!dec_known) |=> (s_shape(2'h1, 2'h1) and instr_illegal);
	endproperty
	a_unk: assert property (p_unk)
		else $error("unknown opcode not flagged as one byte");

endmodule

/* File: testbench/ilt_prog_mem.sv */
`timescale 1ns/1ps

module ilt_prog_mem
	import ilt_pkg::*;
(
	input  wire logic              clock,
	input  wire logic              fetch_req,
	input  wire ilt_pkg::ilt_pc_t  pc,
	input  wire logic              serve,
	input  wire logic [3:0]        stall,
	input  wire logic              stray,
	output logic                   instr_valid,
	output logic [7:0]             instr_byte
);
	// ************************************************************
	// program store, loaded by the bench through hierarchy
	// ************************************************************
	logic [7:0] mem [256];
	logic [3:0] wait_cnt;

	initial begin
		foreach (mem[i]) mem[i] = 8'h00;
		instr_valid = 1'b0;
		instr_byte  = 8'h5A;
		wait_cnt    = 4'h0;
	end

	// ************************************************************
	// opcode supply, changed on the falling edge only
	// ************************************************************
	always @(negedge clock) begin
		if (fetch_req === 1'b1 && serve === 1'b1) begin
			if (wait_cnt < stall) begin
				wait_cnt    <= wait_cnt + 4'h1;
				instr_valid <= 1'b0;
				instr_byte  <= ~instr_byte;
			end else begin
				instr_valid <= 1'b1;
				instr_byte  <= mem[pc[7:0]];
			end
		end else if (fetch_req === 1'b0 && stray === 1'b1) begin
			// junk offered while busy; a short op would show if taken
			wait_cnt    <= 4'h0;
			instr_valid <= 1'b1;
			instr_byte  <= 8'hE4;
		end else begin
			// released bus toggles so a stale byte never looks valid
			wait_cnt    <= 4'h0;
			instr_valid <= 1'b0;
			instr_byte  <= ~instr_byte;
		end
	end
endmodule

/* File: testbench/tb_instruction_length_timing.sv */
`timescale 1ns/1ps

module tb_instruction_length_timing;
	import ilt_pkg::*;

	logic       clock;
	logic       rst_n;
	logic       instr_valid;
	logic [7:0] instr_byte;
	logic       fetch_req;
	ilt_pc_t    pc;
	logic       busy;
	ilt_len_t   instr_len;
	ilt_cyc_t   instr_cycles;
	logic       instr_illegal;
	logic       instr_done;
	logic       serve;
	logic [3:0] stall;
	logic       stray;
	int         err_total;
	int         n_compared;

	ilt_seq dut (
		.clock         (clock),
		.rst_n         (rst_n),
		.instr_valid   (instr_valid),
		.instr_byte    (instr_byte),
		.fetch_req     (fetch_req),
		.pc            (pc),
		.busy          (busy),
		.instr_len     (instr_len),
		.instr_cycles  (instr_cycles),
		.instr_illegal (instr_illegal),
		.instr_done    (instr_done)
	);

	ilt_prog_mem pm (
		.clock       (clock),
		.fetch_req   (fetch_req),
		.pc          (pc),
		.serve       (serve),
		.stall       (stall),
		.stray       (stray),
		.instr_valid (instr_valid),
		.instr_byte  (instr_byte)
	);

	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	// ************************************************************
	// reporting
	// ************************************************************
	task automatic summarize();
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic cmp(input logic [15:0] got, input logic [15:0] exp,
			input string what);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, what, got,
				exp);
		end
	endtask

	// ************************************************************
	// one instruction: place opcode at pc, follow it to done
	// ************************************************************
	task automatic chk(input logic [7:0] op, input ilt_len_t l,
			input ilt_cyc_t c, input logic ill);
		ilt_pc_t p0;
		int      n;
		int      w;
		w = 0;
		while (fetch_req !== 1'b1 && w < 20) begin
			@(posedge clock);
			#1;
			w++;
		end
		if (w >= 20)
			cmp(16'(fetch_req), 16'h0001, "fetch never returned");
		p0 = pc;
		pm.mem[pc[7:0]] = op;
		serve = 1'b1;
		w = 0;
		do begin
			@(posedge clock);
			#1;
			w++;
		end while (busy !== 1'b1 && w < 20);
		if (w >= 20) begin
			cmp(16'(op), 16'hFFFF, "opcode never taken");
			summarize();
		end else begin
			n = 0;
			while (busy === 1'b1 && n < 8) begin
				cmp(16'(instr_done), 16'h0000, "done while busy");
				cmp(16'(fetch_req), 16'h0000, "fetch while busy");
				@(posedge clock);
				#1;
				n++;
			end
			cmp(16'(n), 16'(c), "busy cycles");
			cmp(16'(instr_cycles), 16'(c), "cycle count");
			cmp(16'(instr_len), 16'(l), "byte length");
			cmp(16'(instr_illegal), 16'(ill), "illegal flag");
			cmp(16'(instr_done), 16'h0001, "done pulse");
			cmp(pc, p0 + 16'(l), "pc step");
			cmp(16'(fetch_req), 16'h0001, "fetch after run");
		end
	endtask

	// ************************************************************
	// scenarios
	// ************************************************************
	task automatic t_reset();
		cmp(16'(fetch_req), 16'h0001, "reset fetch_req");
		cmp(16'(busy), 16'h0000, "reset busy");
		cmp(pc, 16'h0000, "reset pc");
		cmp(16'(instr_len), 16'h0000, "reset len");
		cmp(16'(instr_cycles), 16'h0000, "reset cycles");
		cmp(16'(instr_illegal), 16'h0000, "reset illegal");
		cmp(16'(instr_done), 16'h0000, "reset done");
	endtask

	task automatic t_acc_reg();
		logic [7:0] a [7] = '{8'hE4, 8'hF4, 8'h23, 8'h33, 8'h03, 8'h13,
			8'hC4};
		logic [7:0] r [6] = '{8'hE8, 8'hEF, 8'hF8, 8'hFF, 8'hC8, 8'hCF};
		foreach (a[i]) chk(a[i], 2'h1, 2'h1, 1'b0);
		foreach (r[i]) chk(r[i], 2'h1, 2'h1, 1'b0);
	endtask

	task automatic t_two_cycle();
		logic [7:0] ind [6] = '{8'hE6, 8'hE7, 8'hF6, 8'hF7, 8'hC6, 8'hC7};
		logic [7:0] dir [7] = '{8'hE5, 8'hF5, 8'hA8, 8'hAF, 8'h88, 8'h8F,
			8'hC5};
		logic [7:0] imm [5] = '{8'h74, 8'h78, 8'h7F, 8'h76, 8'h77};
		logic [7:0] idr [4] = '{8'h86, 8'h87, 8'hA6, 8'hA7};
		foreach (ind[i]) chk(ind[i], 2'h1, 2'h2, 1'b0);
		foreach (dir[i]) chk(dir[i], 2'h2, 2'h2, 1'b0);
		foreach (imm[i]) chk(imm[i], 2'h2, 2'h2, 1'b0);
		foreach (idr[i]) chk(idr[i], 2'h2, 2'h2, 1'b0);
	endtask

	task automatic t_three();
		logic [7:0] x [6] = '{8'hE2, 8'hE3, 8'hF2, 8'hF3, 8'hE0, 8'hF0};
		chk(8'h85, 2'h3, 2'h3, 1'b0);
		chk(8'h75, 2'h3, 2'h3, 1'b0);
		chk(8'h90, 2'h3, 2'h3, 1'b0);
		chk(8'h93, 2'h1, 2'h3, 1'b0);
		chk(8'h83, 2'h1, 2'h3, 1'b0);
		foreach (x[i]) chk(x[i], 2'h1, 2'h3, 1'b0);
	endtask

	task automatic t_stack_bit();
		logic [7:0] b [4] = '{8'hC2, 8'hD2, 8'hB2, 8'h82};
		chk(8'hC0, 2'h2, 2'h2, 1'b0);
		chk(8'hD0, 2'h2, 2'h2, 1'b0);
		chk(8'hD6, 2'h1, 2'h2, 1'b0);
		chk(8'hD7, 2'h1, 2'h2, 1'b0);
		foreach (b[i]) chk(b[i], 2'h2, 2'h2, 1'b0);
		chk(8'hC3, 2'h1, 2'h1, 1'b0);
		chk(8'hA5, 2'h1, 2'h1, 1'b1);
	endtask

	task automatic t_slow_stray();
		// slow supply plus junk offered while busy must not shorten runs
		stall = 4'h3;
		stray = 1'b1;
		chk(8'h85, 2'h3, 2'h3, 1'b0);
		chk(8'hE6, 2'h1, 2'h2, 1'b0);
		stall = 4'h0;
		stray = 1'b0;
	endtask

	task automatic t_mid_reset();
		chk(8'hE4, 2'h1, 2'h1, 1'b0);
		pm.mem[pc[7:0]] = 8'h90;
		@(posedge clock);
		#1;
		serve = 1'b0;
		cmp(16'(busy), 16'h0001, "long op started");
		@(negedge clock);
		rst_n = 1'b0;
		@(negedge clock);
		rst_n = 1'b1;
		@(posedge clock);
		#1;
		t_reset();
		chk(8'h75, 2'h3, 2'h3, 1'b0);
	endtask

	initial begin
		rst_n      = 1'b0;
		serve      = 1'b0;
		stall      = 4'h0;
		stray      = 1'b0;
		err_total  = 0;
		n_compared = 0;
		repeat (3) @(negedge clock);
		rst_n = 1'b1;
		@(posedge clock);
		#1;
		t_reset();
		t_acc_reg();
		t_two_cycle();
		t_three();
		t_stack_bit();
		t_slow_stray();
		t_mid_reset();
		summarize();
	end
endmodule
